// ---- dv/fl_ctrl_host.sv ----
// Host model that loads control words into the block
`timescale 1ns/1ps
`default_nettype none
module fl_ctrl_host
   import fl_ctrl_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Loaded word
   output logic [23:0] o_word,
   output logic o_word_load
);
   initial begin
      o_word = 24'h000000;
      o_word_load = 1'b0;
   end

   // Caller keeps clear bits low in normal use and sets quarter rate for fast clocks
   task automatic send_word(input logic [23:0] w);
      @(posedge i_clk);
      o_word <= w;
      o_word_load <= 1'b1;
      @(posedge i_clk);
      o_word_load <= 1'b0;
      // Released word no longer holds its value
      o_word <= ~w;
   endtask
endmodule // fl_ctrl_host
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the fastlock and loop auxiliary control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin fails++; \
   $display("unexpected at %0t: got %h want %h", $time, act, exp); end end
module tb
   import fl_ctrl_pkg::*;
;
   typedef struct packed {logic [23:0] word; logic [16:0] outs;} fl_tb_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic power_up = 1'b0;
   logic cmp_event = 1'b0;
   logic [23:0] word;
   logic word_load;
   logic pin, pin_oe, act, ld_event, rf_counter_clear, if_rst, rf_pump_float, if_tri;
   logic [4:0] gain, divide;
   logic [16:0] outs;
   logic seen;
   int fails = 0;
   int checked = 0;
   int ld_cnt = 0;
   int ld_base = 0;
   fl_tb_row_t rows [12];

   always #2.5 clk = ~clk;
   assign outs = {pin, pin_oe, act, gain, divide, rf_counter_clear, if_rst, rf_pump_float, if_tri};
   always @(posedge clk) if (ld_event === 1'b1) ld_cnt <= ld_cnt + 1;

   fl_ctrl_host u_host (.i_clk(clk), .o_word(word), .o_word_load(word_load));
   fl_ctrl_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_word(word), .i_word_load(word_load),
      .i_power_up(power_up), .i_rf_cmp_event(cmp_event), .o_rf_fastlock_pin(pin),
      .o_rf_fastlock_pin_oe(pin_oe), .o_fastlock_active(act), .o_rf_pump_gain(gain),
      .o_csr_divide(divide), .o_rf_ld_event(ld_event), .o_rf_counter_reset(rf_counter_clear),
      .o_if_counter_reset(if_rst), .o_rf_pump_tristate(rf_pump_float),
      .o_if_pump_tristate(if_tri));

   function automatic logic [23:0] fl_word(logic [1:0] c, logic [3:0] p, logic [13:0] t);
      return {c, p, t, FL_SEL_FASTLOCK};
   endfunction
   function automatic logic [23:0] aux_word(int b);
      logic [23:0] w;
      w = 24'h00090f;
      if (b >= 0) w[b] = 1'b1;
      return w;
   endfunction
   function automatic fl_tb_row_t row(logic [23:0] w, logic [2:0] poa, logic [4:0] g,
      logic [4:0] d, logic [3:0] c);
      return '{w, {poa, g, d, c}};
   endfunction

   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic pulse(int n);
      repeat (n) begin
         @(posedge clk) cmp_event <= 1'b1;
         @(posedge clk) cmp_event <= 1'b0;
      end
   endtask
   task automatic end_test(string name);
      $display("test %s done, %0d mismatches so far", name, fails);
   endtask
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      close_out();
   end

   initial begin
      rows[0] = row(fl_word(2'h0, 4'h0, 14'h0000), 3'b000, 5'h01, 5'h01, 4'h0);
      rows[1] = row(fl_word(2'h1, 4'h5, 14'h0001), 3'b011, 5'h06, 5'h02, 4'h0);
      rows[2] = row(fl_word(2'h2, 4'hf, 14'h0001), 3'b011, 5'h10, 5'h04, 4'h0);
      rows[3] = row(fl_word(2'h3, 4'h0, 14'h0001), 3'b011, 5'h01, 5'h10, 4'h0);
      rows[4] = row(fl_word(2'h3, 4'h7, 14'h0002), 3'b010, 5'h01, 5'h01, 4'h0);
      rows[5] = row(fl_word(2'h3, 4'h7, 14'h0003), 3'b110, 5'h01, 5'h01, 4'h0);
      rows[6] = row(fl_word(2'h2, 4'h3, 14'h0004), 3'b010, 5'h01, 5'h01, 4'h0);
      rows[7] = row(aux_word(FL_AUX_RF_CLR), 3'b010, 5'h01, 5'h01, 4'b1010);
      rows[8] = row(aux_word(FL_AUX_IF_CLR), 3'b010, 5'h01, 5'h01, 4'b0101);
      rows[9] = row(aux_word(FL_AUX_RF_FLT), 3'b010, 5'h01, 5'h01, 4'b0010);
      rows[10] = row(aux_word(FL_AUX_IF_FLT), 3'b010, 5'h01, 5'h01, 4'b0001);
      rows[11] = row(aux_word(-1), 3'b010, 5'h01, 5'h01, 4'b0000);
      @(posedge clk) #1;
      `CHK(outs, {3'b000, 5'h01, 5'h01, 4'hf})
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk) #1;
      `CHK(outs[3:2], 2'b11)
      @(posedge clk) #1;
      `CHK(outs[3:0], 4'h0)
      end_test("reset");
      foreach (rows[i]) begin
         u_host.send_word(rows[i].word);
         settle();
         `CHK(outs, rows[i].outs)
      end
      end_test("table");
      ld_base = ld_cnt;
      u_host.send_word(24'h000000);
      settle();
      `CHK(outs[16:4], {3'b111, 5'h04, 5'h04})
      pulse(7);
      settle();
      `CHK(act, 1'b1)
      u_host.send_word(24'h000000);
      pulse(7);
      settle();
      `CHK(act, 1'b1)
      pulse(1);
      settle();
      `CHK(outs[16:4], {3'b010, 5'h01, 5'h01})
      `CHK(ld_cnt - ld_base, 15)
      end_test("timer");
      u_host.send_word(24'h000000);
      settle();
      `CHK(act, 1'b1)
      u_host.send_word(fl_word(2'h0, 4'h0, 14'h0003));
      settle();
      `CHK(outs[16:4], {3'b110, 5'h01, 5'h01})
      end_test("abort");
      u_host.send_word(aux_word(FL_AUX_QRATE));
      settle();
      ld_base = ld_cnt;
      pulse(8);
      settle();
      `CHK(ld_cnt - ld_base, 2)
      u_host.send_word(aux_word(-1));
      end_test("quarter rate");
      @(posedge clk) power_up <= 1'b1;
      @(posedge clk) power_up <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
         @(posedge clk) #1;
         seen = seen | (rf_counter_clear & if_rst);
      end
      `CHK(seen, 1'b1)
      settle();
      `CHK(outs[3:2], 2'b00)
      end_test("power up");
      close_out();
   end
endmodule // tb
`default_nettype wire

// ---- verilog/fl_ctrl_pkg.sv ----
// Package for the fastlock and loop auxiliary control block
package fl_ctrl_pkg;
   localparam int FL_TOC_W = 14;
   localparam logic [13:0] FL_TOC_HIZ = 14'h0000;
   localparam logic [13:0] FL_TOC_MANUAL = 14'h0001;
   localparam logic [13:0] FL_TOC_LOW = 14'h0002;
   localparam logic [13:0] FL_TOC_HIGH = 14'h0003;
   localparam logic [13:0] FL_TOC_MIN_EN = 14'h0004;
   localparam logic [3:0] FL_SEL_FASTLOCK = 4'hd;
   localparam logic [3:0] FL_SEL_AUX = 4'hf;
   localparam logic [3:0] FL_SEL_FREQ = 4'h0;
   localparam int FL_CSR_HI = 23;
   localparam int FL_CSR_LO = 22;
   localparam int FL_CPF_HI = 21;
   localparam int FL_CPF_LO = 18;
   localparam int FL_TOC_HI = 17;
   localparam int FL_TOC_LO = 4;
   localparam int FL_AUX_QRATE = 13;
   localparam int FL_AUX_IF_CLR = 7;
   localparam int FL_AUX_RF_CLR = 6;
   localparam int FL_AUX_IF_FLT = 5;
   localparam int FL_AUX_RF_FLT = 4;
   localparam logic [1:0] FL_QRATE_LAST = 2'h3;
   localparam logic [4:0] FL_GAIN_NORMAL = 5'h01;
   localparam logic [4:0] FL_DIV_1 = 5'h01;
   localparam logic [4:0] FL_DIV_2 = 5'h02;
   localparam logic [4:0] FL_DIV_4 = 5'h04;
   localparam logic [4:0] FL_DIV_16 = 5'h10;

   typedef struct packed {
      logic [1:0] cycle_slip_reduction;
      logic [3:0] pump;
      logic [13:0] timeout;
   } fl_ctrl_cfg_t;

   typedef struct packed {
      logic quarter_rate;
      logic if_clear;
      logic rf_clear;
      logic if_float;
      logic rf_float;
   } fl_ctrl_aux_t;

   typedef enum logic [1:0] {
      FL_ST_IDLE = 2'b00,
      FL_ST_FAST = 2'b01
   } fl_ctrl_state_t;
endpackage

// ---- verilog/fl_ctrl_timer.sv ----
// Fastlock timeout counter driven by comparison events
`timescale 1ns/1ps
`default_nettype none
module fl_ctrl_timer
   import fl_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Control
   input wire logic i_start,
   input wire logic i_abort,
   input wire logic [13:0] i_timeout,
   input wire logic i_event,
   // Status
   output logic o_active
);
   logic [14:0] remain_r;
   fl_ctrl_state_t state_r;

   // Holds for twice the programmed value in comparison events
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= FL_ST_IDLE;
         remain_r <= '0;
      end else if (i_abort) begin
         state_r <= FL_ST_IDLE;
         remain_r <= '0;
      end else if (i_start) begin
         state_r <= FL_ST_FAST;
         remain_r <= {i_timeout, 1'b0};
      end else begin
         unique case (state_r)
            FL_ST_IDLE: begin
               remain_r <= '0;
            end
            FL_ST_FAST: begin
               if (i_event) begin
                  remain_r <= remain_r - 15'h0001;
                  if (remain_r == 15'h0001) begin
                     state_r <= FL_ST_IDLE;
                  end
               end
            end
            default: begin
               state_r <= FL_ST_IDLE;
            end
         endcase
      end
   end

   assign o_active = (state_r == FL_ST_FAST);

   chk_count_to_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state_r == FL_ST_FAST && i_event && remain_r == 15'h0001 && !i_start && !i_abort)
      |=> state_r == FL_ST_IDLE) else $error("fastlock did not end on last event");
   chk_start_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_start && !i_abort) |=> (remain_r == {$past(i_timeout), 1'b0}) && o_active)
      else $error("fastlock start load wrong");
endmodule // fl_ctrl_timer
`default_nettype wire

// ---- verilog/fl_ctrl_top.sv ----
// Fastlock, cycle-slip and loop auxiliary control of the synthesizer
// Behaviour
// - Timeout 0..3 disables timed fastlock; pin is general tri-statable output.
// - Timeout 4..16383 enables fastlock; pin shows fastlock indication.
// - Fastlock lasts twice the timeout in comparison events.
// - Timeout 0 high-Z, 1 low plus manual fastlock, 2 low, 3 high.
// - Fastlock pump gain is field plus one, 1X to 16X.
// - Cycle-slip field gives rate divide 1, 2, 4 or 16.
// - Quarter-rate bit divides RF lock-detect comparison by 4; IF untouched.
// - IF clear bit resets IF counters and floats IF pump.
// - RF clear bit resets RF counters and floats RF pump.
// - Power-up applies counter reset automatically.
// - RF float bit floats RF pump, counters keep running.
// - IF float bit floats IF pump, counters keep running.
// - Word: cycle-slip 23:22, pump 21:18, timeout 17:4, select 3:0.
`timescale 1ns/1ps
`default_nettype none
module fl_ctrl_top
   import fl_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Loaded control word from the serial link
   input wire logic [23:0] i_word,
   input wire logic i_word_load,
   // Power-up and comparison events
   input wire logic i_power_up,
   input wire logic i_rf_cmp_event,
   // Fastlock pin
   output logic o_rf_fastlock_pin,
   output logic o_rf_fastlock_pin_oe,
   // Loop controls
   output logic o_fastlock_active,
   output logic [4:0] o_rf_pump_gain,
   output logic [4:0] o_csr_divide,
   output logic o_rf_ld_event,
   output logic o_rf_counter_reset,
   output logic o_if_counter_reset,
   output logic o_rf_pump_tristate,
   output logic o_if_pump_tristate
);
   fl_ctrl_cfg_t cfg_r;
   fl_ctrl_aux_t aux_r;
   logic [1:0] qdiv_r;
   logic pwr_clr_r;
   logic timer_active;
   logic timer_start;
   logic fast_on;
   logic [4:0] pump_gain_nxt;
   logic [4:0] csr_div_nxt;

   function automatic logic [4:0] fl_csr_div(input logic [1:0] code);
      unique case (code)
         2'h0: fl_csr_div = FL_DIV_1;
         2'h1: fl_csr_div = FL_DIV_2;
         2'h2: fl_csr_div = FL_DIV_4;
         2'h3: fl_csr_div = FL_DIV_16;
      endcase
   endfunction

   // Fastlock configuration word
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_r <= '0;
      end else if (i_word_load && i_word[3:0] == FL_SEL_FASTLOCK) begin
         cfg_r.cycle_slip_reduction <= i_word[FL_CSR_HI:FL_CSR_LO];
         cfg_r.pump <= i_word[FL_CPF_HI:FL_CPF_LO];
         cfg_r.timeout <= i_word[FL_TOC_HI:FL_TOC_LO];
      end
   end

   // Auxiliary control word
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aux_r <= '0;
      end else if (i_word_load && i_word[3:0] == FL_SEL_AUX) begin
         aux_r.quarter_rate <= i_word[FL_AUX_QRATE];
         aux_r.if_clear <= i_word[FL_AUX_IF_CLR];
         aux_r.rf_clear <= i_word[FL_AUX_RF_CLR];
         aux_r.if_float <= i_word[FL_AUX_IF_FLT];
         aux_r.rf_float <= i_word[FL_AUX_RF_FLT];
      end
   end

   // Frequency word loads start fastlock when enabled
   assign timer_start = i_word_load && i_word[3:0] == FL_SEL_FREQ
      && cfg_r.timeout >= FL_TOC_MIN_EN;

   fl_ctrl_timer u_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_start(timer_start),
      .i_abort(cfg_r.timeout < FL_TOC_MIN_EN),
      .i_timeout(cfg_r.timeout),
      .i_event(i_rf_cmp_event),
      .o_active(timer_active)
   );

   // Timer state lags an abort by one edge, so gate it with the live timeout
   assign fast_on = (timer_active && cfg_r.timeout >= FL_TOC_MIN_EN)
      || cfg_r.timeout == FL_TOC_MANUAL;
   assign pump_gain_nxt = fast_on ? {1'b0, cfg_r.pump} + FL_GAIN_NORMAL
      : FL_GAIN_NORMAL;
   assign csr_div_nxt = fast_on ? fl_csr_div(cfg_r.cycle_slip_reduction) : FL_DIV_1;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fastlock_active <= 1'b0;
         o_rf_pump_gain <= FL_GAIN_NORMAL;
         o_csr_divide <= FL_DIV_1;
      end else begin
         o_fastlock_active <= fast_on;
         o_rf_pump_gain <= pump_gain_nxt;
         o_csr_divide <= csr_div_nxt;
      end
   end

   // Fastlock pin function
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rf_fastlock_pin <= 1'b0;
         o_rf_fastlock_pin_oe <= 1'b0;
      end else begin
         unique case (cfg_r.timeout)
            FL_TOC_HIZ: begin
               o_rf_fastlock_pin <= 1'b0;
               o_rf_fastlock_pin_oe <= 1'b0;
            end
            FL_TOC_MANUAL, FL_TOC_LOW: begin
               o_rf_fastlock_pin <= 1'b0;
               o_rf_fastlock_pin_oe <= 1'b1;
            end
            FL_TOC_HIGH: begin
               o_rf_fastlock_pin <= 1'b1;
               o_rf_fastlock_pin_oe <= 1'b1;
            end
            default: begin
               o_rf_fastlock_pin <= timer_active;
               o_rf_fastlock_pin_oe <= 1'b1;
            end
         endcase
      end
   end

   // Lock-detect quarter-rate divider on RF events only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         qdiv_r <= '0;
         o_rf_ld_event <= 1'b0;
      end else begin
         if (i_rf_cmp_event) begin
            qdiv_r <= qdiv_r + 2'h1;
         end
         o_rf_ld_event <= i_rf_cmp_event
            && (!aux_r.quarter_rate || qdiv_r == FL_QRATE_LAST);
      end
   end

   // Power-up counter reset, held for two cycles
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pwr_clr_r <= 1'b1;
      end else begin
         pwr_clr_r <= i_power_up;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rf_counter_reset <= 1'b1;
         o_if_counter_reset <= 1'b1;
         o_rf_pump_tristate <= 1'b1;
         o_if_pump_tristate <= 1'b1;
      end else begin
         o_rf_counter_reset <= aux_r.rf_clear || pwr_clr_r || i_power_up;
         o_if_counter_reset <= aux_r.if_clear || pwr_clr_r || i_power_up;
         o_rf_pump_tristate <= aux_r.rf_clear || aux_r.rf_float;
         o_if_pump_tristate <= aux_r.if_clear || aux_r.if_float;
      end
   end

   chk_manual_forces: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cfg_r.timeout == FL_TOC_MANUAL |=> o_fastlock_active && !o_rf_fastlock_pin
      && o_rf_fastlock_pin_oe) else $error("manual fastlock not forced");
   chk_hiz_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cfg_r.timeout == FL_TOC_HIZ |=> !o_rf_fastlock_pin_oe)
      else $error("pin not high impedance");
   chk_high_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cfg_r.timeout == FL_TOC_HIGH |=> o_rf_fastlock_pin && !o_fastlock_active)
      else $error("pin not driven high");
   chk_pin_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cfg_r.timeout >= FL_TOC_MIN_EN |=> o_rf_fastlock_pin == $past(timer_active))
      else $error("pin does not show fastlock");
   chk_pump_gain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      fast_on |=> o_rf_pump_gain == {1'b0, $past(cfg_r.pump)} + FL_GAIN_NORMAL)
      else $error("fastlock gain wrong");
   chk_gain_restore: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !fast_on |=> o_rf_pump_gain == FL_GAIN_NORMAL && o_csr_divide == FL_DIV_1)
      else $error("normal settings not restored");
   chk_csr_sixteen: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      fast_on && cfg_r.cycle_slip_reduction == 2'h3 |=> o_csr_divide == FL_DIV_16)
      else $error("cycle slip divide wrong");
   chk_rf_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      aux_r.rf_clear |=> o_rf_counter_reset && o_rf_pump_tristate)
      else $error("rf clear not applied");
   chk_if_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      aux_r.if_clear |=> o_if_counter_reset && o_if_pump_tristate)
      else $error("if clear not applied");
   chk_float_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (aux_r.rf_float && !aux_r.rf_clear && !pwr_clr_r && !i_power_up)
      |=> o_rf_pump_tristate && !o_rf_counter_reset)
      else $error("rf float wrong");
   chk_if_float: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (aux_r.if_float && !aux_r.if_clear && !pwr_clr_r && !i_power_up)
      |=> o_if_pump_tristate && !o_if_counter_reset)
      else $error("if float wrong");
   // Both counter resets stand for the two cycles after the power-up cycle
   sequence fl_pwr_clr_hold;
      (o_rf_counter_reset && o_if_counter_reset) [*2];
   endsequence
   chk_power_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_power_up |=> fl_pwr_clr_hold)
      else $error("power-up reset missing");
   chk_quarter_rate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      aux_r.quarter_rate && i_rf_cmp_event && qdiv_r != FL_QRATE_LAST |=> !o_rf_ld_event)
      else $error("lock detect not divided");
endmodule // fl_ctrl_top
`default_nettype wire
